// >>> logic/spm_consts.vh
// named constants for the strap pin-function mux
// assumes inclusion by bare name from every design file of the block
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// ****************************************
// register port
// ****************************************
`define SPM_ADDR_W        4
`define SPM_DATA_W        8
`define SPM_OFS_PC        4'h0
`define SPM_OFS_GPO       4'h1
`define SPM_OFS_GPIO_OUT  4'h2
`define SPM_OFS_GPIO_DIR  4'h3
`define SPM_OFS_GPIO_IN   4'h4
`define SPM_OFS_STATUS    4'h5

// ****************************************
// reset values and field layout
// ****************************************
`define SPM_RST_BYTE      8'h00
`define SPM_RST_NIB       4'h0
`define SPM_RST_BIT       1'b0
`define SPM_RST_BIT_HI    1'b1
`define SPM_GPO_LSB       0
`define SPM_GPO_MSB       5
`define SPM_DPC_LSB       6
`define SPM_DPC_MSB       7
`define SPM_ST_CAPT       0
`define SPM_ST_NOTEBOOK   1
`define SPM_ST_KBC_LSB    4
`define SPM_ST_KBC_MSB    7
`define SPM_ST_ZERO_LSB   2
`define SPM_ST_ZERO_MSB   3
`define SPM_ST_ZERO       2'h0

// ****************************************
// strap encoding and pin groups
// ****************************************
`define SPM_STRAP_NOTEBOOK 1'b0
`define SPM_STRAP_W        5
`define SPM_STRAP_NB_BIT   0
`define SPM_STRAP_KBC_LSB  1
`define SPM_MA_LOW_LSB     0
`define SPM_ALL_NIB        4'hF
`define SPM_KBC_W          4
`define SPM_CLKSEL_W       4
`define SPM_GPIO_W         8
`define SPM_GPO_W          6
`define SPM_DPC_W          2
`define SPM_MA_W           12
`define SPM_MA_LOW_MSB     3
`define SPM_MA_HIGH_LSB    4
`define SPM_MA_HIGH_MSB    11
`define SPM_PC_W           8
`define SPM_RAS_W          4

`endif

// >>> logic/spm_sync3.v
// three-stage input synchroniser with an agreement filter
// assumes the input is asynchronous to clk; stages carry no reset so they keep
// sampling while the block is held in reset
`include "spm_consts.vh"

module spm_sync3 #(
  parameter W = 1
) (
  clk,
  din,
  dout,
  agree
);
  input  wire         clk;
  input  wire [W-1:0] din;
  output wire [W-1:0] dout;
  output wire         agree;

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] filt_r;

  // ****************************************
  // chain; s1 feeds only s2
  // ****************************************
  always @(posedge clk)
  begin
    s1_r <= din;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (s2_r == s3_r)
    begin
      filt_r <= s3_r;
    end
  end

  assign agree = (s2_r == s3_r);
  assign dout  = filt_r;

endmodule // spm_sync3

// >>> logic/spm_strap_latch.v
// one-shot capture of the board straps after power-on reset ends
// assumes synchronised, filtered strap levels and an agreement flag
`include "spm_consts.vh"

module spm_strap_latch (
  clk,
  rst,
  strap_val,
  strap_agree,
  captured,
  notebook_mode,
  kbc_port
);
  input  wire                     clk;
  input  wire                     rst;
  input  wire [`SPM_STRAP_W-1:0]  strap_val;
  input  wire                     strap_agree;
  output wire                     captured;
  output wire                     notebook_mode;
  output wire [`SPM_KBC_W-1:0]    kbc_port;

  reg                    captured_r;
  reg                    notebook_r;
  reg [`SPM_KBC_W-1:0]   kbc_r;

  // ****************************************
  // capture once, hold until next reset
  // ****************************************
  // reset loads constants only; the straps are taken by the clocked path after
  // release, and only once the filter agrees so a bouncing strap cannot latch
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      captured_r <= `SPM_RST_BIT;
      notebook_r <= `SPM_RST_BIT;
      kbc_r      <= `SPM_RST_NIB;
    end
    else if (!captured_r && strap_agree)
    begin
      captured_r <= `SPM_RST_BIT_HI;
      notebook_r <= (strap_val[`SPM_STRAP_NB_BIT] == `SPM_STRAP_NOTEBOOK);
      kbc_r      <= strap_val[`SPM_STRAP_W-1:`SPM_STRAP_KBC_LSB];
    end
  end

  assign captured      = captured_r;
  assign notebook_mode = notebook_r;
  assign kbc_port      = kbc_r;

endmodule // spm_strap_latch

// >>> logic/spm_pin_mux.v
// strap-selected pin-function multiplexer of a pc system controller
// assumes one 25 MHz clock, a power-on reset held at least four clock edges,
// and a core that supplies dram, cache and bank-select functions on plain ports
// limitation: the keyboard port reports the level captured at reset, not the live pins
//
// Design decisions made here: the address-and-strobe port and the address map.
`include "spm_consts.vh"

module spm_pin_mux (
  clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  notebook_select_strap,
  clock_freq_select_straps,
  dram_cycle,
  dram_addr,
  core_ras_n,
  core_high_bank_select_n,
  core_low_bank_select_n,
  core_byte_we_n,
  desk_gp_out,
  desk_gp_oe,
  desk_gp_in,
  general_bidir_pins_in,
  general_bidir_pins_out,
  general_bidir_pins_oe,
  low_dram_addr_pins_in,
  low_dram_addr_pins_out,
  low_dram_addr_pins_oe,
  upper_dram_addr_pins,
  peripheral_latch_write_strobe_n,
  ras_pins_n,
  high_bank_select_n,
  low_bank_select_n,
  general_output_pins,
  notebook_mode,
  kbc_reset_input_port
);
  input  wire                      clk;
  input  wire                      rst;
  input  wire [`SPM_ADDR_W-1:0]    reg_addr;
  input  wire [`SPM_DATA_W-1:0]    reg_wdata;
  input  wire                      reg_wr;
  input  wire                      reg_rd;
  output wire [`SPM_DATA_W-1:0]    reg_rdata;
  input  wire                      notebook_select_strap;
  input  wire [`SPM_CLKSEL_W-1:0]  clock_freq_select_straps;
  input  wire                      dram_cycle;
  input  wire [`SPM_MA_W-1:0]      dram_addr;
  input  wire [`SPM_RAS_W-1:0]     core_ras_n;
  input  wire                      core_high_bank_select_n;
  input  wire                      core_low_bank_select_n;
  input  wire [`SPM_GPO_W-1:0]     core_byte_we_n;
  input  wire [`SPM_GPIO_W-1:0]    desk_gp_out;
  input  wire [`SPM_GPIO_W-1:0]    desk_gp_oe;
  output wire [`SPM_GPIO_W-1:0]    desk_gp_in;
  input  wire [`SPM_GPIO_W-1:0]    general_bidir_pins_in;
  output wire [`SPM_GPIO_W-1:0]    general_bidir_pins_out;
  output wire [`SPM_GPIO_W-1:0]    general_bidir_pins_oe;
  input  wire [`SPM_KBC_W-1:0]     low_dram_addr_pins_in;
  output wire [`SPM_KBC_W-1:0]     low_dram_addr_pins_out;
  output wire [`SPM_KBC_W-1:0]     low_dram_addr_pins_oe;
  output wire [`SPM_PC_W-1:0]      upper_dram_addr_pins;
  output wire                      peripheral_latch_write_strobe_n;
  output wire [`SPM_RAS_W-1:0]     ras_pins_n;
  output wire                      high_bank_select_n;
  output wire                      low_bank_select_n;
  output wire [`SPM_GPO_W-1:0]     general_output_pins;
  output wire                      notebook_mode;
  output wire [`SPM_KBC_W-1:0]     kbc_reset_input_port;

  // ****************************************
  // declarations
  // ****************************************
  reg  [`SPM_PC_W-1:0]    output_port_config_reg_r;
  reg  [`SPM_DATA_W-1:0]  gpo_ctrl_r;
  reg  [`SPM_GPIO_W-1:0]  gpio_out_r;
  reg  [`SPM_GPIO_W-1:0]  gpio_dir_r;
  reg  [`SPM_DATA_W-1:0]  rdata_r;
  reg  [`SPM_DATA_W-1:0]  rdata_nxt;
  reg  [`SPM_PC_W-1:0]    ma_high_r;
  reg  [`SPM_KBC_W-1:0]   ma_low_r;
  reg  [`SPM_KBC_W-1:0]   ma_low_oe_r;
  reg                     pc_shown_r;
  reg                     peripheral_latch_write_strobe_n_r;

  wire [`SPM_STRAP_W-1:0] strap_raw;
  wire [`SPM_STRAP_W-1:0] strap_val;
  wire                    strap_agree;
  wire [`SPM_GPIO_W-1:0]  gpio_in_sync;
  wire                    captured;
  wire                    nb_mode;
  wire [`SPM_KBC_W-1:0]   kbc_port;
  wire                    run_nb;
  wire                    run_desk;

  // ****************************************
  // strap sampling and capture
  // ****************************************
  // the keyboard port shares the strap chain so both are taken in the same cycle
  assign strap_raw = {low_dram_addr_pins_in, notebook_select_strap};

  spm_sync3 #(
    .W (`SPM_STRAP_W)
  ) u_strap_sync (
    .clk   (clk),
    .din   (strap_raw),
    .dout  (strap_val),
    .agree (strap_agree)
  );

  spm_strap_latch u_strap_latch (
    .clk           (clk),
    .rst           (rst),
    .strap_val     (strap_val),
    .strap_agree   (strap_agree),
    .captured      (captured),
    .notebook_mode (nb_mode),
    .kbc_port      (kbc_port)
  );

  // the general pins get their own chain; its agreement flag is left open because
  // the filtered value is only read by software, never latched once
  spm_sync3 #(
    .W (`SPM_GPIO_W)
  ) u_gpio_sync (
    .clk   (clk),
    .din   (general_bidir_pins_in),
    .dout  (gpio_in_sync),
    .agree ()
  );

  // run-time functions apply only once the straps are held
  assign run_nb   = captured & nb_mode;
  assign run_desk = captured & ~nb_mode;
  // before capture neither run mode holds, so every shared pin but the general outputs, which pass the core byte write enables, rests in its reset-time role

  assign notebook_mode        = nb_mode;
  assign kbc_reset_input_port = kbc_port;

  // ****************************************
  // register port
  // ****************************************
  // writes to the input and status offsets fall to the default arm and change nothing;
  // status is read-only so software cannot fake a strap level
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      output_port_config_reg_r <= `SPM_RST_BYTE;
      gpo_ctrl_r               <= `SPM_RST_BYTE;
      gpio_out_r               <= `SPM_RST_BYTE;
      gpio_dir_r               <= `SPM_RST_BYTE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SPM_OFS_PC:       output_port_config_reg_r <= reg_wdata;
        `SPM_OFS_GPO:      gpo_ctrl_r               <= reg_wdata;
        `SPM_OFS_GPIO_OUT: gpio_out_r               <= reg_wdata;
        `SPM_OFS_GPIO_DIR: gpio_dir_r               <= reg_wdata;
        default:           gpio_dir_r               <= gpio_dir_r;
      endcase
    end
  end

  // the input port reads zero in desktop mode, where the pins belong to the core,
  // so software can tell that the port is absent
  always @*
  begin
    rdata_nxt = `SPM_RST_BYTE;
    case (reg_addr)
      `SPM_OFS_PC:       rdata_nxt = output_port_config_reg_r;
      `SPM_OFS_GPO:      rdata_nxt = gpo_ctrl_r;
      `SPM_OFS_GPIO_OUT: rdata_nxt = gpio_out_r;
      `SPM_OFS_GPIO_DIR: rdata_nxt = gpio_dir_r;
      `SPM_OFS_GPIO_IN:  rdata_nxt = run_nb ? gpio_in_sync : `SPM_RST_BYTE;
      `SPM_OFS_STATUS:
      begin
        rdata_nxt[`SPM_ST_CAPT]                     = captured;
        rdata_nxt[`SPM_ST_NOTEBOOK]                 = nb_mode;
        rdata_nxt[`SPM_ST_ZERO_MSB:`SPM_ST_ZERO_LSB] = `SPM_ST_ZERO;
        rdata_nxt[`SPM_ST_KBC_MSB:`SPM_ST_KBC_LSB]   = kbc_port;
      end
      default:           rdata_nxt = `SPM_RST_BYTE;
    endcase
  end

  // read data stand only in the cycle after the strobe
  // zero outside that cycle keeps stale data off the port
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= `SPM_RST_BYTE;
    end
    else if (reg_rd)
    begin
      rdata_r <= rdata_nxt;
    end
    else
    begin
      rdata_r <= `SPM_RST_BYTE;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // shared dram address pins
  // ****************************************
  // registered so the pins change on one clean edge; the latch strobe rises on
  // the same edge that address replaces the control bits, so the external latch
  // relies on its own hold time across that edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ma_high_r   <= `SPM_RST_BYTE;
      ma_low_r    <= `SPM_RST_NIB;
      ma_low_oe_r <= `SPM_RST_NIB;
      pc_shown_r  <= `SPM_RST_BIT;
      peripheral_latch_write_strobe_n_r    <= `SPM_RST_BIT_HI;
    end
    else if (!captured)
    begin
      // low pins stay inputs while the keyboard port is being sampled
      ma_low_oe_r <= `SPM_RST_NIB;
      pc_shown_r  <= `SPM_RST_BIT;
      peripheral_latch_write_strobe_n_r    <= `SPM_RST_BIT_HI;
    end
    else if (dram_cycle)
    begin
      // a dram cycle lifts the strobe on the same edge that the pins turn to address
      ma_high_r   <= dram_addr[`SPM_MA_HIGH_MSB:`SPM_MA_HIGH_LSB];
      ma_low_r    <= dram_addr[`SPM_MA_LOW_MSB:`SPM_MA_LOW_LSB];
      ma_low_oe_r <= `SPM_ALL_NIB;
      pc_shown_r  <= `SPM_RST_BIT;
      peripheral_latch_write_strobe_n_r    <= `SPM_RST_BIT_HI;
    end
    else
    begin
      ma_high_r   <= output_port_config_reg_r;
      // the low pins keep the core address outside dram cycles; only the upper byte is shared
      ma_low_r    <= dram_addr[`SPM_MA_LOW_MSB:`SPM_MA_LOW_LSB];
      ma_low_oe_r <= `SPM_ALL_NIB;
      pc_shown_r  <= `SPM_RST_BIT_HI;
      // strobe only once the pins already show the control bits
      peripheral_latch_write_strobe_n_r    <= ~pc_shown_r;
    end
  end

  assign upper_dram_addr_pins            = ma_high_r;
  assign low_dram_addr_pins_out          = ma_low_r;
  assign low_dram_addr_pins_oe           = ma_low_oe_r;
  assign peripheral_latch_write_strobe_n = peripheral_latch_write_strobe_n_r;

  // ****************************************
  // row strobes and bank selects
  // ****************************************
  // combinational so the clock generator sees its selection as soon as reset asserts;
  // the core must keep its row strobes inactive until capture, as they reach the pins
  // the moment the straps are held
  assign ras_pins_n = captured ? core_ras_n
                               : clock_freq_select_straps;

  // before capture both selects rest high, so neither a bank nor a power switch
  // is touched while the mode is still undecided
  assign high_bank_select_n = run_nb   ? gpo_ctrl_r[`SPM_DPC_LSB]
                            : run_desk ? core_high_bank_select_n
                            : `SPM_RST_BIT_HI;
  assign low_bank_select_n  = run_nb   ? gpo_ctrl_r[`SPM_DPC_MSB]
                            : run_desk ? core_low_bank_select_n
                            : `SPM_RST_BIT_HI;

  // ****************************************
  // general outputs and bidirectional pins
  // ****************************************
  // outside notebook mode the core byte write enables pass straight through; their timing is the core's
  assign general_output_pins = run_nb ? gpo_ctrl_r[`SPM_GPO_MSB:`SPM_GPO_LSB]
                                      : core_byte_we_n;

  // desktop mode hands the pins, tag bits six and seven included, to the core
  assign general_bidir_pins_out = run_nb ? gpio_out_r : desk_gp_out;
  // in notebook mode enables follow the direction register bit for bit; a pin set to input is left to the board
  assign general_bidir_pins_oe  = run_nb   ? gpio_dir_r
                                : run_desk ? desk_gp_oe
                                : `SPM_RST_BYTE;
  assign desk_gp_in = run_desk ? general_bidir_pins_in : `SPM_RST_BYTE;

endmodule // spm_pin_mux

// >>> sim/spm_pin_mux_asserts.sv
// concurrent checks for the strap pin-function mux, bound into spm_pin_mux
// assumes only the top ports; shadows follow every register write
module spm_pin_mux_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic [3:0]  clock_freq_select_straps,
  input wire logic        dram_cycle,
  input wire logic [11:0] dram_addr,
  input wire logic [3:0]  core_ras_n,
  input wire logic        core_high_bank_select_n,
  input wire logic        core_low_bank_select_n,
  input wire logic [5:0]  core_byte_we_n,
  input wire logic [7:0]  desk_gp_out,
  input wire logic [7:0]  desk_gp_oe,
  input wire logic [7:0]  desk_gp_in,
  input wire logic [7:0]  general_bidir_pins_in,
  input wire logic [7:0]  general_bidir_pins_out,
  input wire logic [7:0]  general_bidir_pins_oe,
  input wire logic [3:0]  low_dram_addr_pins_out,
  input wire logic [3:0]  low_dram_addr_pins_oe,
  input wire logic [7:0]  upper_dram_addr_pins,
  input wire logic        peripheral_latch_write_strobe_n,
  input wire logic [3:0]  ras_pins_n,
  input wire logic        high_bank_select_n,
  input wire logic        low_bank_select_n,
  input wire logic [5:0]  general_output_pins,
  input wire logic        notebook_mode,
  input wire logic [3:0]  kbc_reset_input_port
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // helper logic
  // ****************************************
  // run gates out the capture edges, where modes are still settling
  logic [1:0] cnt_r;
  logic [7:0] pc_r, gpo_r, go_r, gd_r;
  wire        run = (cnt_r == 2'h3);
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt_r <= 2'h0;
      pc_r  <= 8'h00;
      gpo_r <= 8'h00;
      go_r  <= 8'h00;
      gd_r  <= 8'h00;
    end
    else
    begin
      if (!run) cnt_r <= cnt_r + 2'h1;
      if (reg_wr && reg_addr == 4'h0) pc_r <= reg_wdata;
      if (reg_wr && reg_addr == 4'h1) gpo_r <= reg_wdata;
      if (reg_wr && reg_addr == 4'h2) go_r <= reg_wdata;
      if (reg_wr && reg_addr == 4'h3) gd_r <= reg_wdata;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // assertions
  // ****************************************
  property p_strap_rst;
    $fell(rst) |-> ras_pins_n == clock_freq_select_straps && high_bank_select_n && low_bank_select_n
      && low_dram_addr_pins_oe == 4'h0;
  endproperty
  a_strap_rst: assert property (p_strap_rst) else $error("row strobes or selects wrong at reset");
  property p_ma_dram;
    run && dram_cycle |=> {upper_dram_addr_pins, low_dram_addr_pins_out} == $past(dram_addr)
      && low_dram_addr_pins_oe == 4'hF && peripheral_latch_write_strobe_n;
  endproperty
  a_ma_dram: assert property (p_ma_dram) else $error("dram address not on pins");
  property p_ma_pc;
    run && !dram_cycle && !reg_wr |=> upper_dram_addr_pins == $past(pc_r);
  endproperty
  a_ma_pc: assert property (p_ma_pc) else $error("control bits not on pins");
  property p_strobe;
    run && !dram_cycle ##1 !dram_cycle |=> !peripheral_latch_write_strobe_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("latch strobe not low");
  property p_ras_run;
    run |-> ras_pins_n == core_ras_n;
  endproperty
  a_ras_run: assert property (p_ras_run) else $error("row strobes not from core");
  property p_desk;
    run && !notebook_mode |-> high_bank_select_n == core_high_bank_select_n
      && low_bank_select_n == core_low_bank_select_n && general_output_pins == core_byte_we_n;
  endproperty
  a_desk: assert property (p_desk) else $error("desktop outputs wrong");
  property p_note;
    run && notebook_mode |-> {low_bank_select_n, high_bank_select_n, general_output_pins} == gpo_r;
  endproperty
  a_note: assert property (p_note) else $error("notebook outputs wrong");
  property p_gp_desk;
    run && !notebook_mode |-> general_bidir_pins_out == desk_gp_out && general_bidir_pins_oe == desk_gp_oe
      && desk_gp_in == general_bidir_pins_in;
  endproperty
  a_gp_desk: assert property (p_gp_desk) else $error("desktop bidir pins wrong");
  property p_gp_note;
    run && notebook_mode |-> general_bidir_pins_oe == gd_r && (general_bidir_pins_out & gd_r) == (go_r & gd_r)
      && desk_gp_in == 8'h00;
  endproperty
  a_gp_note: assert property (p_gp_note) else $error("notebook bidir pins wrong");
  property p_hold;
    run |-> $stable(notebook_mode) && $stable(kbc_reset_input_port);
  endproperty
  a_hold: assert property (p_hold) else $error("strap selection changed");
  c_dram: cover property (run && dram_cycle);
  c_latch: cover property (run && $fell(peripheral_latch_write_strobe_n));
  c_note: cover property (run && notebook_mode);
endmodule // spm_pin_mux_chk

bind spm_pin_mux spm_pin_mux_chk u_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .clock_freq_select_straps,
  .dram_cycle, .dram_addr, .core_ras_n, .core_high_bank_select_n, .core_low_bank_select_n, .core_byte_we_n,
  .desk_gp_out, .desk_gp_oe, .desk_gp_in, .general_bidir_pins_in, .general_bidir_pins_out, .general_bidir_pins_oe,
  .low_dram_addr_pins_out, .low_dram_addr_pins_oe, .upper_dram_addr_pins, .peripheral_latch_write_strobe_n,
  .ras_pins_n, .high_bank_select_n, .low_bank_select_n, .general_output_pins, .notebook_mode, .kbc_reset_input_port);

// >>> sim/spm_far_side.sv
// far side: strap resistors on the low address pins, bidir pin wiring, peripheral latch
// assumes the bench sets strap and external pin levels
module spm_far_side (
  input  wire logic       clk,
  input  wire logic [3:0] kbc_v,
  input  wire logic [7:0] ext_v,
  input  wire logic [3:0] low_dram_addr_pins_out,
  input  wire logic [3:0] low_dram_addr_pins_oe,
  output wire logic [3:0] low_dram_addr_pins_in,
  input  wire logic [7:0] general_bidir_pins_out,
  input  wire logic [7:0] general_bidir_pins_oe,
  output wire logic [7:0] general_bidir_pins_in,
  input  wire logic [7:0] upper_dram_addr_pins,
  input  wire logic       peripheral_latch_write_strobe_n,
  output logic      [7:0] latch_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // strap resistors, or the external level on the bidir pins, win wherever the device leaves a pin undriven
  assign low_dram_addr_pins_in = (low_dram_addr_pins_out & low_dram_addr_pins_oe)
    | (kbc_v & ~low_dram_addr_pins_oe);
  assign general_bidir_pins_in = (general_bidir_pins_out & general_bidir_pins_oe)
    | (ext_v & ~general_bidir_pins_oe);
  // takes the pins at each edge while the strobe is low; using the values from before the edge
  // stands in for the latch hold time where the strobe rises and the pins return to address at once
  always_ff @(posedge clk)
    if (!peripheral_latch_write_strobe_n)
      latch_q <= upper_dram_addr_pins;
endmodule // spm_far_side

// >>> sim/tb_top.sv
// self-checking bench for the strap pin-function mux
// assumes the far-side model resolves shared pins; inputs move on rising edges
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0, clock_freq_select_straps = 4'h5, core_ras_n = 4'hF, kbc_v = 4'hA;
  logic [7:0]  reg_wdata = 8'h00, desk_gp_out = 8'h96, desk_gp_oe = 8'h3C, ext_v = 8'h5A;
  logic        notebook_select_strap = 1'b1, dram_cycle = 1'b1;
  logic        core_high_bank_select_n = 1'b1, core_low_bank_select_n = 1'b0;
  logic [11:0] dram_addr = 12'h000;
  logic [5:0]  core_byte_we_n = 6'h2D;
  wire  [7:0]  reg_rdata, desk_gp_in, general_bidir_pins_in, general_bidir_pins_out, general_bidir_pins_oe;
  wire  [7:0]  upper_dram_addr_pins, latch_q;
  wire  [3:0]  low_dram_addr_pins_in, low_dram_addr_pins_out, low_dram_addr_pins_oe, ras_pins_n;
  wire  [3:0]  kbc_reset_input_port;
  wire  [5:0]  general_output_pins;
  wire         peripheral_latch_write_strobe_n, high_bank_select_n, low_bank_select_n, notebook_mode;
  int          n_mismatch = 0;
  int          checked = 0;
  always #20 clk = ~clk;
  spm_pin_mux uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .notebook_select_strap,
    .clock_freq_select_straps, .dram_cycle, .dram_addr, .core_ras_n, .core_high_bank_select_n,
    .core_low_bank_select_n, .core_byte_we_n, .desk_gp_out, .desk_gp_oe, .desk_gp_in, .general_bidir_pins_in,
    .general_bidir_pins_out, .general_bidir_pins_oe, .low_dram_addr_pins_in, .low_dram_addr_pins_out,
    .low_dram_addr_pins_oe, .upper_dram_addr_pins, .peripheral_latch_write_strobe_n, .ras_pins_n,
    .high_bank_select_n, .low_bank_select_n, .general_output_pins, .notebook_mode, .kbc_reset_input_port);
  spm_far_side u_far (.clk, .kbc_v, .ext_v, .low_dram_addr_pins_out, .low_dram_addr_pins_oe, .low_dram_addr_pins_in,
    .general_bidir_pins_out, .general_bidir_pins_oe, .general_bidir_pins_in, .upper_dram_addr_pins,
    .peripheral_latch_write_strobe_n, .latch_q);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, {4'h0, e}, {4'h0, reg_rdata});
  endtask
  // sync chain is unreset; four edges of reset let all three stages and the filter fill with the new straps
  task automatic boot(input logic s, input logic [3:0] k, input logic [3:0] c);
    @(posedge clk);
    rst <= 1'b1;
    notebook_select_strap <= s;
    kbc_v <= k;
    clock_freq_select_straps <= c;
    cyc(3);
    chk("ras at reset", {8'h0, c}, {8'h0, ras_pins_n});
    chk("sel at reset", 12'h003, {10'h0, high_bank_select_n, low_bank_select_n});
    @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    chk("mode", {11'h0, ~s}, {11'h0, notebook_mode});
    chk("kbc port", {8'h0, k}, {8'h0, kbc_reset_input_port});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_desktop;
    boot(1'b1, 4'hA, 4'h5);
    rd("status", 4'h5, 8'hA1);
    @(posedge clk);
    core_ras_n <= 4'h6;
    core_byte_we_n <= 6'h1B;
    core_high_bank_select_n <= 1'b0;
    core_low_bank_select_n <= 1'b1;
    cyc(1);
    chk("ras", 12'h006, {8'h0, ras_pins_n});
    chk("bank sel", 12'h001, {10'h0, high_bank_select_n, low_bank_select_n});
    chk("gpo", 12'h01B, {6'h0, general_output_pins});
    chk("gp oe", 12'h03C, {4'h0, general_bidir_pins_oe});
    chk("gp out", 12'h096, {4'h0, general_bidir_pins_out});
    chk("gp in", 12'h056, {4'h0, desk_gp_in});
    rd("gpio in", 4'h4, 8'h00);
    $display("test desktop done");
  endtask
  task automatic t_shared;
    wr(4'h0, 8'h5C);
    @(posedge clk);
    dram_cycle <= 1'b0;
    cyc(3);
    chk("pc bits", 12'h05C, {4'h0, upper_dram_addr_pins});
    chk("strobe", 12'h000, {11'h0, peripheral_latch_write_strobe_n});
    chk("latch", 12'h05C, {4'h0, latch_q});
    @(posedge clk);
    dram_cycle <= 1'b1;
    dram_addr <= 12'hABC;
    cyc(2);
    chk("dram addr", 12'hABC, {upper_dram_addr_pins, low_dram_addr_pins_out});
    chk("ma oe", 12'h00F, {8'h0, low_dram_addr_pins_oe});
    chk("strobe idle", 12'h001, {11'h0, peripheral_latch_write_strobe_n});
    chk("latch held", 12'h05C, {4'h0, latch_q});
    $display("test shared pins done");
  endtask
  task automatic t_regs;
    rd("unmapped", 4'hF, 8'h00);
    wr(4'h5, 8'hFF);
    rd("status ro", 4'h5, 8'hA1);
    wr(4'h2, 8'h3E);
    rd("gpio out", 4'h2, 8'h3E);
    $display("test registers done");
  endtask
  task automatic t_notebook;
    boot(1'b0, 4'h3, 4'h9);
    rd("status", 4'h5, 8'h33);
    wr(4'h1, 8'hC5);
    cyc(1);
    chk("gpo", 12'h005, {6'h0, general_output_pins});
    chk("dpc", 12'h003, {10'h0, high_bank_select_n, low_bank_select_n});
    wr(4'h1, 8'h6A);
    cyc(1);
    chk("gpo", 12'h02A, {6'h0, general_output_pins});
    chk("dpc", 12'h002, {10'h0, high_bank_select_n, low_bank_select_n});
    wr(4'h2, 8'hC3);
    wr(4'h3, 8'hF0);
    cyc(1);
    chk("gp oe", 12'h0F0, {4'h0, general_bidir_pins_oe});
    chk("gp out", 12'h0C0, {4'h0, general_bidir_pins_out & 8'hF0});
    chk("desk in", 12'h000, {4'h0, desk_gp_in});
    cyc(4);
    rd("gpio in", 4'h4, 8'hCA);
    @(posedge clk);
    notebook_select_strap <= 1'b1;
    cyc(6);
    chk("mode held", 12'h001, {11'h0, notebook_mode});
    $display("test notebook done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    t_desktop();
    t_shared();
    t_regs();
    t_notebook();
    give_verdict();
  end
  // the tests need under a hundred cycles; five thousand means a hang
  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule // tb_top
